//--- rtl/cbr_top.sv
// Capability registers, masked clock gating and brown-out control
//
// How it works
// RQ1 - RAM size field reads 0x07
// RQ2 - Flash size field reads 0x03
// RQ3 - Gating writes masked by capability bits
// RQ4 - Unmarked group-0 gating bits stay zero
// RQ5 - Converter rate write clipped to maximum
// RQ6 - Core capability bits 4..0 read one
// RQ7 - Peripheral capability bits read as present
// RQ8 - Pin capability bits read as present
// RQ9 - Port capability bits 2..0 read one
// RQ10 - Capability registers ignore all writes
// RQ11 - Reserved bits read zero, software preserves
// RQ12 - Delay field resets 0x1FFF, counts periods
// RQ13 - Delay counter exceeds 10000 periods
// RQ14 - Action bit selects reset or interrupt
// RQ15 - Filter waits, re-samples, reports if asserted
// RQ16 - Deasserted re-sample suppresses the event
// RQ17 - Filter off reports immediately
// RQ18 - Oscillator fault flags set by hardware
// RQ19 - Counter restarts per assertion, stops at delay
`include "cbr_cfg.svh"
`default_nettype none
module cbr_top
  import cbr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Brown-out and oscillator inputs
  input  wire logic        brownout_detect,
  input  wire logic        boot_oscillator,
  input  wire logic        boot_osc_fault,
  input  wire logic        main_osc_fault,
  // Outputs to the system
  output logic             irq,
  output logic             brownout_reset,
  output logic [31:0]      run_gate_group0,
  output logic [31:0]      sleep_gate_group0,
  output logic [31:0]      deep_sleep_gate_group0,
  output logic [31:0]      run_gate_group1,
  output logic [31:0]      sleep_gate_group1,
  output logic [31:0]      deep_sleep_gate_group1,
  output logic [31:0]      run_gate_group2,
  output logic [31:0]      sleep_gate_group2,
  output logic [31:0]      deep_sleep_gate_group2
);
  // ==========================================================
  // Register map, byte offsets in address bits 11:0
  // Memory sizes at 0x008, fixed
  // Core features at 0x010, fixed, masks group 0
  // Peripherals at 0x014, fixed, masks group 1
  // Pins at 0x018, fixed
  // Ports at 0x01C, fixed, masks group 2
  // Brown-out control at 0x030, bits 15:0 writable:
  // Delay in 15:2, action in 1, filter enable in 0
  // Group 0 gating at 0x100, 0x104, 0x108: run, sleep, deep
  // Group 1 gating at 0x110, 0x114, 0x118, same order
  // Group 2 gating at 0x120, 0x124, 0x128, same order
  // Sticky status at 0x140, write one to clear
  // Status bit 0 brown-out, 1 and 2 oscillator faults
  // Interrupt mask at 0x144, same layout as status
  // Other offsets read zero and drop writes
  // ==========================================================
  // Bus timing
  // No wait states, so hreadyout stays high
  // Read data is picked at the address edge
  // Write data lands at the end of the data phase
  // A read right after a write to one word sees the old
  // Value, as both land on one edge
  // Transfer size is ignored; only whole words are decoded
  // ==========================================================
  // Brown-out path
  // Detector passes two flops, then the filter
  // Filter off: one event per rising level
  // Filter on: count oscillator periods, then re-sample
  // Action bit sends the event to status or to reset
  // Reset request is one cycle; the system stretches it
  // ==========================================================
  // Limitations
  // Oscillator is sampled as a level: above half of
  // The bus clock periods are lost and the wait grows
  // Clock enable low also stalls the bus; start no transfer
  // Reserved bits read zero, but software keeps them
  // A fault that stays high sets its flag again each
  // Cycle, so a clear only holds once the fault drops
  // ==========================================================
  // State
  // All registers live in one packed struct
  typedef struct packed {
    logic        wr_pend;  // Write data phase pending
    logic [11:0] wr_addr;  // Latched write offset
    logic [31:0] rdata;    // Read data
    logic [31:0] bor_ctl;  // Brown-out control
    logic [8:0][31:0] gate; // Gating registers, three groups of three
    logic [31:0] istat;    // Sticky interrupt status
    logic [31:0] imask;    // Interrupt mask
    logic        osc_d;    // Boot oscillator level, last cycle
    logic        rst_o;    // Brown-out reset output
  } cbr_top_t;
  cbr_top_t st_ff, nxt_st;

  // Combinational helpers
  logic        det_s;     // Synchronised detector
  logic        osc_s;     // Synchronised boot oscillator
  logic        fault_b_s; // Synchronised boot oscillator fault
  logic        fault_m_s; // Synchronised main oscillator fault
  logic        bor_ev;    // Filtered brown-out event
  logic        osc_tick;  // One boot-oscillator period seen
  logic        addr_ph;   // Valid address phase
  logic [31:0] ev_set;    // Events this cycle
  logic [31:0] wmask;     // Capability mask for a write
  logic [31:0] wval;      // Masked write value
  integer      gidx;      // Gating register index

  // ==========================================================
  // Capability mask of a gating register group
  function automatic logic [31:0] cap_of(input logic [11:0] a);
    logic [31:0] m;
    m = 32'h0000_0000;
    if (a >= `CBR_OFS_RUN0 && a <= `CBR_OFS_DSL0) begin
      m = `CBR_CORE_VAL; // RQ3 RQ4
    end else if (a >= `CBR_OFS_RUN1 && a <= `CBR_OFS_DSL1) begin
      m = `CBR_PERI_VAL; // RQ3
    end else if (a >= `CBR_OFS_RUN2 && a <= `CBR_OFS_DSL2) begin
      m = `CBR_PORT_VAL; // RQ3
    end
    return m;
  endfunction

  // Gating register index from offset, or -1
  function automatic integer gate_idx(input logic [11:0] a);
    integer i;
    i = -1;
    case (a)
      `CBR_OFS_RUN0: i = 0;
      `CBR_OFS_SLP0: i = 1;
      `CBR_OFS_DSL0: i = 2;
      `CBR_OFS_RUN1: i = 3;
      `CBR_OFS_SLP1: i = 4;
      `CBR_OFS_DSL1: i = 5;
      `CBR_OFS_RUN2: i = 6;
      `CBR_OFS_SLP2: i = 7;
      `CBR_OFS_DSL2: i = 8;
      default:       i = -1;
    endcase
    return i;
  endfunction

  // ==========================================================
  // Synchronisers for asynchronous levels
  cbr_sync u_sync_det (
    .clk (ref_clk),
    .rst (rst),
    .ce  (clk_en),
    .d   (brownout_detect),
    .q   (det_s)
  );
  // Boot oscillator, edges counted below
  cbr_sync u_sync_osc (
    .clk (ref_clk),
    .rst (rst),
    .ce  (clk_en),
    .d   (boot_oscillator),
    .q   (osc_s)
  );
  // Boot oscillator fault level
  cbr_sync u_sync_bof (
    .clk (ref_clk),
    .rst (rst),
    .ce  (clk_en),
    .d   (boot_osc_fault),
    .q   (fault_b_s)
  );
  // Main oscillator fault level
  cbr_sync u_sync_mof (
    .clk (ref_clk),
    .rst (rst),
    .ce  (clk_en),
    .d   (main_osc_fault),
    .q   (fault_m_s)
  );

  // Rising oscillator edge marks one period; a fast oscillator
  // beyond half the bus clock undercounts, making the wait longer
  assign osc_tick = osc_s & ~st_ff.osc_d;

  // ==========================================================
  // Brown-out filter
  // Delay field and filter bit come from brown-out control
  cbr_filter u_filter (
    .clk      (ref_clk),
    .rst      (rst),
    .ce       (clk_en),
    .osc_tick (osc_tick),
    .detect   (det_s),
    .filt_en  (st_ff.bor_ctl[`CBR_FLT_BIT]),
    .delay    (st_ff.bor_ctl[`CBR_DLY_MSB:`CBR_DLY_LSB]),
    .event_p  (bor_ev)
  );

  // Selected, ready, NONSEQ or SEQ
  assign addr_ph = hsel & hready & htrans[1];

  // ==========================================================
  // Next state: bus, registers, events
  always_comb begin
    // Everything holds unless changed below
    nxt_st = st_ff;
    ev_set = 32'h0000_0000;
    wmask = 32'h0000_0000;
    wval = 32'h0000_0000;
    gidx = -1;
    if (clk_en) begin
      nxt_st.osc_d = osc_s;
      // Events; the action bit picks reset or interrupt
      if (bor_ev && !st_ff.bor_ctl[`CBR_ACT_BIT]) begin
        ev_set[`CBR_IRQ_BOR] = 1'b1; // RQ14
      end
      nxt_st.rst_o = bor_ev & st_ff.bor_ctl[`CBR_ACT_BIT]; // RQ14
      // Fault levels set their flags each cycle
      ev_set[`CBR_IRQ_BOF] = fault_b_s; // RQ18
      ev_set[`CBR_IRQ_MOF] = fault_m_s; // RQ18
      // Write data phase
      if (st_ff.wr_pend) begin
        nxt_st.wr_pend = 1'b0;
        // Group mask for gating writes, rate clip for group 0 only
        gidx = gate_idx(st_ff.wr_addr);
        wmask = cap_of(st_ff.wr_addr);
        wval = hwdata & wmask; // RQ3 RQ4
        if (gidx >= 0 && gidx <= 2) begin
          // Clip the converter rate to its maximum
          if (hwdata[`CBR_RATE_MSB:`CBR_RATE_LSB] > `CBR_RATE_MAX) begin
            wval[`CBR_RATE_MSB:`CBR_RATE_LSB] = `CBR_RATE_MAX; // RQ5
          end else begin
            wval[`CBR_RATE_MSB:`CBR_RATE_LSB] =
              hwdata[`CBR_RATE_MSB:`CBR_RATE_LSB]; // RQ5
          end
        end
        // Store the masked word
        if (gidx >= 0) begin
          nxt_st.gate[gidx] = wval;
        end
        // Control, status and mask words
        case (st_ff.wr_addr)
          `CBR_OFS_BOR: begin
            nxt_st.bor_ctl = hwdata & `CBR_BOR_MASK; // RQ11
          end
          `CBR_OFS_ISTAT: begin
            nxt_st.istat = st_ff.istat & ~(hwdata & `CBR_IRQ_MASK);
          end
          `CBR_OFS_IMASK: begin
            nxt_st.imask = hwdata & `CBR_IRQ_MASK;
          end
          default: begin
            // Capability registers and holes ignore writes RQ10
          end
        endcase
      end
      // Set wins over a clear in the same cycle
      nxt_st.istat = nxt_st.istat | ev_set;
      // Address phase
      if (addr_ph) begin
        nxt_st.wr_pend = hwrite;
        nxt_st.wr_addr = haddr[11:0];
        nxt_st.rdata = 32'h0000_0000;
        // Read data chosen now, shown next cycle
        if (!hwrite) begin
          gidx = gate_idx(haddr[11:0]);
          if (gidx >= 0) begin
            nxt_st.rdata = st_ff.gate[gidx];
          end
          case (haddr[11:0])
            `CBR_OFS_MEM:   nxt_st.rdata = `CBR_MEM_VAL;  // RQ1 RQ2
            `CBR_OFS_CORE:  nxt_st.rdata = `CBR_CORE_VAL; // RQ6
            `CBR_OFS_PERI:  nxt_st.rdata = `CBR_PERI_VAL; // RQ7
            `CBR_OFS_PIN:   nxt_st.rdata = `CBR_PIN_VAL;  // RQ8
            `CBR_OFS_PORT:  nxt_st.rdata = `CBR_PORT_VAL; // RQ9
            `CBR_OFS_BOR:   nxt_st.rdata = st_ff.bor_ctl;
            `CBR_OFS_ISTAT: nxt_st.rdata = st_ff.istat;
            `CBR_OFS_IMASK: nxt_st.rdata = st_ff.imask;
            default: begin
              // Unmapped reads return zero with OKAY
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Register all state
  // Sync reset; clock enable does not hold it back
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff.wr_pend <= 1'b0;
      st_ff.wr_addr <= 12'h000;
      st_ff.rdata <= 32'h0000_0000;
      st_ff.bor_ctl <= `CBR_BOR_RST; // RQ12 RQ14 RQ15
      st_ff.gate <= '0;
      st_ff.istat <= 32'h0000_0000;
      st_ff.imask <= 32'h0000_0000;
      st_ff.osc_d <= 1'b0;
      st_ff.rst_o <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  // Bus answer: zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;

  // Level interrupt from sticky status and mask
  assign irq = |(st_ff.istat & st_ff.imask);
  // Reset request pulse
  assign brownout_reset = st_ff.rst_o;

  // Group 0 gating, masked by core features
  assign run_gate_group0 = st_ff.gate[0];
  assign sleep_gate_group0 = st_ff.gate[1];
  assign deep_sleep_gate_group0 = st_ff.gate[2];

  // Group 1 gating, masked by peripherals
  assign run_gate_group1 = st_ff.gate[3];
  assign sleep_gate_group1 = st_ff.gate[4];
  assign deep_sleep_gate_group1 = st_ff.gate[5];

  // Group 2 gating, masked by ports
  assign run_gate_group2 = st_ff.gate[6];
  assign sleep_gate_group2 = st_ff.gate[7];
  assign deep_sleep_gate_group2 = st_ff.gate[8];
endmodule
`default_nettype wire

//--- rtl/cbr_cfg.svh
// Constants for the capability and brown-out register bank
`ifndef CBR_CFG_SVH
`define CBR_CFG_SVH
// ==========================================================
// Register byte offsets
`define CBR_OFS_MEM      12'h008
`define CBR_OFS_CORE     12'h010
`define CBR_OFS_PERI     12'h014
`define CBR_OFS_PIN      12'h018
`define CBR_OFS_PORT     12'h01C
`define CBR_OFS_BOR      12'h030
`define CBR_OFS_RUN0     12'h100
`define CBR_OFS_SLP0     12'h104
`define CBR_OFS_DSL0     12'h108
`define CBR_OFS_RUN1     12'h110
`define CBR_OFS_SLP1     12'h114
`define CBR_OFS_DSL1     12'h118
`define CBR_OFS_RUN2     12'h120
`define CBR_OFS_SLP2     12'h124
`define CBR_OFS_DSL2     12'h128
`define CBR_OFS_ISTAT    12'h140
`define CBR_OFS_IMASK    12'h144
// ==========================================================
// Fixed capability contents
`define CBR_MEM_VAL      32'h0007_0003
`define CBR_CORE_VAL     32'h0000_001F
`define CBR_PERI_VAL     32'h0303_0011
`define CBR_PIN_VAL      32'h8100_03C0
`define CBR_PORT_VAL     32'h0000_0007
// Converter rate field in group-0 gating and its maximum
`define CBR_RATE_LSB     8
`define CBR_RATE_MSB     9
`define CBR_RATE_MAX     2'h0
// ==========================================================
// Brown-out control fields and reset
`define CBR_BOR_MASK     32'h0000_FFFF
`define CBR_BOR_RST      32'h0000_7FFD
`define CBR_DLY_MSB      15
`define CBR_DLY_LSB      2
`define CBR_ACT_BIT      1
`define CBR_FLT_BIT      0
// Interrupt status bits
`define CBR_IRQ_BOR      0
`define CBR_IRQ_BOF      1
`define CBR_IRQ_MOF      2
`define CBR_IRQ_MASK     32'h0000_0007
`endif

//--- rtl/cbr_pkg.sv
// Types shared by the capability and brown-out bank
`default_nettype none
package cbr_pkg;
  // Filter sequencer states, one-hot
  typedef enum logic [2:0] {
    CBR_IDLE = 3'h1,
    CBR_WAIT = 3'h2,
    CBR_HOLD = 3'h4
  } cbr_fsm_t;
endpackage
`default_nettype wire

//--- rtl/cbr_sync.sv
// Two-flop synchroniser for detector, boot oscillator and fault levels
`default_nettype none
module cbr_sync
  import cbr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  // ==========================================================
  // State
  typedef struct packed {
    logic s1; // First stage, read only by s2
    logic s2; // Output stage
  } cbr_sync_t;
  cbr_sync_t st_ff, nxt_st;

  // Shift the level through
  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule
`default_nettype wire

//--- rtl/cbr_filter.sv
// Brown-out detector filter counting boot-oscillator periods
`include "cbr_cfg.svh"
`default_nettype none
module cbr_filter
  import cbr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        osc_tick,
  input  wire logic        detect,
  input  wire logic        filt_en,
  input  wire logic [13:0] delay,
  output logic             event_p
);
  // ==========================================================
  // State
  typedef struct packed {
    cbr_fsm_t    fsm;   // Sequencer
    logic [13:0] cnt;   // Periods waited, 14 bits reach past 10000
    logic        det_d; // Detector, last cycle
    logic        ev;    // Event pulse
  } cbr_filt_t;
  cbr_filt_t st_ff, nxt_st;
  logic rise;

  // Sequencer: wait, re-sample, report or drop
  always_comb begin
    nxt_st = st_ff;
    rise = detect & ~st_ff.det_d;
    if (ce) begin
      nxt_st.det_d = detect;
      nxt_st.ev = 1'b0;
      case (st_ff.fsm)
        CBR_IDLE: begin
          if (rise && !filt_en) begin
            nxt_st.ev = 1'b1; // RQ17
          end else if (rise) begin
            nxt_st.cnt = '0; // RQ19
            nxt_st.fsm = CBR_WAIT;
          end
        end
        CBR_WAIT: begin
          // Count only boot-oscillator periods, stop at the delay
          if (rise) begin
            nxt_st.cnt = '0; // RQ19
          end else if (st_ff.cnt >= delay) begin // RQ19
            nxt_st.fsm = CBR_IDLE;
            if (detect) begin
              nxt_st.ev = 1'b1; // RQ15
              nxt_st.fsm = CBR_HOLD;
            end // Deasserted: noise, nothing reported RQ16
          end else if (osc_tick) begin
            nxt_st.cnt = st_ff.cnt + 14'h0001; // RQ12 RQ13
          end
        end
        CBR_HOLD: begin
          // One report per assertion; rearm on release
          if (!detect) begin
            nxt_st.fsm = CBR_IDLE;
          end
        end
        default: begin
          nxt_st.fsm = CBR_IDLE;
        end
      endcase
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '{fsm: CBR_IDLE, cnt: '0, det_d: 1'b0, ev: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign event_p = st_ff.ev;
endmodule
`default_nettype wire

//--- tb/cbr_top_monitor.sv
// Port-level checker for the capability and brown-out bank
`include "cbr_cfg.svh"
`default_nettype none
module cbr_top_monitor
  import cbr_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        brownout_reset,
  input wire logic [31:0] run_gate_group0,
  input wire logic [31:0] sleep_gate_group0,
  input wire logic [31:0] deep_sleep_gate_group0,
  input wire logic [31:0] run_gate_group1,
  input wire logic [31:0] sleep_gate_group1,
  input wire logic [31:0] deep_sleep_gate_group1,
  input wire logic [31:0] run_gate_group2,
  input wire logic [31:0] sleep_gate_group2,
  input wire logic [31:0] deep_sleep_gate_group2
);
  // ==========================================================
  // Clocking; reset silences every check
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Address phase accepted by the slave
  sequence take(a, w);
    hsel && hready && htrans[1] && clk_en && haddr[11:0] == a && hwrite == w;
  endsequence
  // Read answer appears in the data phase
  property p_rd(a, v);
    take(a, 1'b0) |=> hrdata == v;
  endproperty
  // ==========================================================
  // Fixed capability contents
  chk_mem_read: assert property (p_rd(`CBR_OFS_MEM, `CBR_MEM_VAL))
    else $error("memory size read wrong");
  chk_core_read: assert property (p_rd(`CBR_OFS_CORE, `CBR_CORE_VAL))
    else $error("core capability read wrong");
  chk_peri_read: assert property (p_rd(`CBR_OFS_PERI, `CBR_PERI_VAL))
    else $error("peripheral capability read wrong");
  chk_pin_read: assert property (p_rd(`CBR_OFS_PIN, `CBR_PIN_VAL))
    else $error("pin capability read wrong");
  chk_port_read: assert property (p_rd(`CBR_OFS_PORT, `CBR_PORT_VAL))
    else $error("port capability read wrong");
  // ==========================================================
  // Gating outputs never hold a bit the capability lacks
  chk_group0_mask: assert property (((run_gate_group0 | sleep_gate_group0
    | deep_sleep_gate_group0) & ~`CBR_CORE_VAL) == 32'h0000_0000)
    else $error("group0 gating bit outside mask");
  chk_group12_mask: assert property (((run_gate_group1 | sleep_gate_group1
    | deep_sleep_gate_group1) & ~`CBR_PERI_VAL) == 32'h0000_0000
    && ((run_gate_group2 | sleep_gate_group2 | deep_sleep_gate_group2)
    & ~`CBR_PORT_VAL) == 32'h0000_0000)
    else $error("group1 or group2 gating bit outside mask");
  chk_rate_clip: assert property (run_gate_group0[9:8] == `CBR_RATE_MAX)
    else $error("converter rate above maximum");
  // Written word lands masked at the end of the data phase
  chk_gate_write: assert property (take(`CBR_OFS_RUN0, 1'b1) ##1 clk_en
    |=> run_gate_group0 == ($past(hwdata) & `CBR_CORE_VAL))
    else $error("group0 run gating not masked write");
  // Reset request is a single-cycle pulse
  chk_bor_pulse: assert property ($rose(brownout_reset) |=> !brownout_reset)
    else $error("brown-out reset pulse too long");
endmodule
bind cbr_top cbr_top_monitor u_mon (.ref_clk, .rst, .clk_en, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .brownout_reset,
  .run_gate_group0, .sleep_gate_group0, .deep_sleep_gate_group0,
  .run_gate_group1, .sleep_gate_group1, .deep_sleep_gate_group1,
  .run_gate_group2, .sleep_gate_group2, .deep_sleep_gate_group2);
`default_nettype wire

//--- tb/cbr_top_tb.sv
// Self-checking bench for the capability and brown-out bank
`include "cbr_cfg.svh"
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  fails++; $display("wrong value at %0t: got %h expected %h", \
  $time, got, exp); end end
module cbr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rst, hsel, hwrite, clk_en; // Clock, reset, bus
  logic [31:0] haddr, hwdata;                // Address and write data
  logic [1:0]  htrans;                       // Transfer kind
  logic        det, osc_in, bfault, mfault;  // Detector, oscillator, faults
  wire  logic  hreadyout, hresp, irq, bor_rst; // Slave answers, events
  wire  logic [31:0] hrdata;                 // Read data
  wire  logic [31:0] gate [9];               // All nine gating outputs
  int          fails, total_checks, cyc, pulses; // Counters
  // Size tied: only whole words are used
  cbr_top dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .brownout_detect(det),
    .boot_oscillator(osc_in), .boot_osc_fault(bfault),
    .main_osc_fault(mfault), .irq(irq), .brownout_reset(bor_rst),
    .run_gate_group0(gate[0]), .sleep_gate_group0(gate[1]),
    .deep_sleep_gate_group0(gate[2]), .run_gate_group1(gate[3]),
    .sleep_gate_group1(gate[4]), .deep_sleep_gate_group1(gate[5]),
    .run_gate_group2(gate[6]), .sleep_gate_group2(gate[7]),
    .deep_sleep_gate_group2(gate[8]));
  // ==========================================================
  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Boot oscillator at an eighth of the clock; pulse count; timeout
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    osc_in <= cyc[2];
    if (bor_rst === 1'b1) begin
      pulses <= pulses + 1;
    end
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end
  // ==========================================================
  // Bus helpers; no wait-state count assumed, timeout ends a hang
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do begin @(posedge ref_clk); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge ref_clk); end while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // ==========================================================
  // Capability contents, write immunity, unmapped read
  task automatic t_caps;
    logic [11:0] o [5] = '{12'h008, 12'h010, 12'h014, 12'h018, 12'h01C};
    logic [31:0] v [5] = '{32'h0007_0003, 32'h0000_001F, 32'h0303_0011,
                           32'h8100_03C0, 32'h0000_0007};
    for (int i = 0; i < 5; i++) begin
      rd(o[i], v[i]);
      wr(o[i], 32'h0000_0000);
      rd(o[i], v[i]);
    end
    rd(12'h0FC, 32'h0000_0000);
    rd(`CBR_OFS_BOR, 32'h0000_7FFD);
    wr(`CBR_OFS_BOR, 32'h0000_FFFF);
    rd(`CBR_OFS_BOR, 32'h0000_FFFF);
    $display("caps test done");
  endtask
  // Gating writes through each group's capability mask
  task automatic t_gate;
    logic [31:0] m [3] = '{32'h0000_001F, 32'h0303_0011, 32'h0000_0007};
    logic [11:0] a;
    for (int i = 0; i < 9; i++) begin
      a = 12'h100 + 12'(16 * (i / 3) + 4 * (i % 3));
      wr(a, 32'hFFFF_FFFF);
      tick(1);
      `CHK(gate[i], m[i / 3])
      rd(a, m[i / 3]);
    end
    wr(`CBR_OFS_RUN0, 32'h0000_0300);
    rd(`CBR_OFS_RUN0, 32'h0000_0000);
    $display("gate test done");
  endtask
  // Unfiltered events: interrupt with mask, then reset pulse
  task automatic t_fast;
    int p;
    wr(`CBR_OFS_BOR, 32'h0000_0010);
    wr(`CBR_OFS_IMASK, 32'h0000_0001);
    det <= 1'b1;
    tick(3);
    det <= 1'b0;
    tick(10);
    `CHK(irq, 1'b1)
    rd(`CBR_OFS_ISTAT, 32'h0000_0001);
    wr(`CBR_OFS_IMASK, 32'h0000_0000);
    tick(1);
    `CHK(irq, 1'b0)
    wr(`CBR_OFS_ISTAT, 32'h0000_0001);
    rd(`CBR_OFS_ISTAT, 32'h0000_0000);
    wr(`CBR_OFS_BOR, 32'h0000_0012);
    p = pulses;
    det <= 1'b1;
    tick(3);
    det <= 1'b0;
    tick(10);
    `CHK(pulses - p, 1)
    rd(`CBR_OFS_ISTAT, 32'h0000_0000);
    $display("fast test done");
  endtask
  // Filtered events: held assertion reported late, glitch dropped
  task automatic t_filt;
    wr(`CBR_OFS_BOR, 32'h0000_0011);
    det <= 1'b1;
    tick(12);
    rd(`CBR_OFS_ISTAT, 32'h0000_0000);
    tick(60);
    rd(`CBR_OFS_ISTAT, 32'h0000_0001);
    det <= 1'b0;
    wr(`CBR_OFS_ISTAT, 32'h0000_0001);
    tick(5);
    det <= 1'b1;
    tick(6);
    det <= 1'b0;
    tick(80);
    rd(`CBR_OFS_ISTAT, 32'h0000_0000);
    $display("filter test done");
  endtask
  // Oscillator fault flags and their clearing
  task automatic t_fault;
    bfault <= 1'b1;
    tick(3);
    bfault <= 1'b0;
    mfault <= 1'b1;
    tick(3);
    mfault <= 1'b0;
    tick(3);
    rd(`CBR_OFS_ISTAT, 32'h0000_0006);
    wr(`CBR_OFS_ISTAT, 32'h0000_0006);
    rd(`CBR_OFS_ISTAT, 32'h0000_0000);
    $display("fault test done");
  endtask
  // Enable low freezes the fault path; mid-run reset restores
  task automatic t_hold;
    clk_en <= 1'b0;
    bfault <= 1'b1;
    tick(5);
    bfault <= 1'b0;
    tick(3);
    clk_en <= 1'b1;
    rd(`CBR_OFS_ISTAT, 32'h0000_0000);
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(2);
    `CHK(gate[3], 32'h0000_0000)
    rd(`CBR_OFS_BOR, 32'h0000_7FFD);
    $display("hold test done");
  endtask
  // ==========================================================
  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst, hsel, hwrite, det, bfault, mfault, clk_en} = 7'h41;
    {haddr, hwdata, htrans} = '0;
    {fails, total_checks, cyc, pulses} = '0;
    tick(3);
    rst <= 1'b0;
    tick(2);
    t_caps();
    t_gate();
    t_fast();
    t_filt();
    t_fault();
    t_hold();
    conclude();
  end
endmodule
`default_nettype wire
